// ### sim/peripheral_control_bank_props.sv
// port assertions for the peripheral control bank
// assumes a bind onto peripheral_control_bank; one clock domain, async low reset
`default_nettype none

module peripheral_control_bank_props (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pwm_ch_one_enable,
   input wire logic p51_oe,
   input wire logic ext_irq_enable,
   input wire logic ext_irq_n,
   input wire logic port5_bit0_in,
   input wire logic port5_bit0_read,
   input wire logic cmp_enable,
   input wire logic opamp_enable,
   input wire logic cmp_pin_drive,
   input wire logic p60_oe,
   input wire logic timer_one_run,
   input wire logic timer_one_tick,
   input wire logic timer_two_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // the shortest timer prescale ratio is 1:2, so a timer tick never lasts two cycles
   sequence pulse_once(t);
      t ##1 !t;
   endsequence

   a_pwm_pin_take: assert property (
      $past(pwm_ch_one_enable) && pwm_ch_one_enable |-> !p51_oe) else $error("p51 not driven");
   a_irq_masked: assert property (
      !ext_irq_enable && !$past(ext_irq_enable) |-> ext_irq_n) else $error("irq not masked");
   a_irq_follows_pin: assert property (
      $past(rst_b) && ext_irq_enable && $past(ext_irq_enable)
      |-> ext_irq_n == $past(port5_bit0_in)) else $error("irq does not follow pin");
   a_pin_readback: assert property (
      $past(rst_b) |-> port5_bit0_read == $past(port5_bit0_in)) else $error("pin read stale");
   a_opamp_decode: assert property (
      opamp_enable |-> cmp_pin_drive && cmp_enable) else $error("opamp decode wrong");
   a_pin_drive_cmp: assert property (
      cmp_pin_drive |-> cmp_enable) else $error("pin drive without comparator");
   a_cmp_pin_take: assert property (
      $past(cmp_pin_drive) && cmp_pin_drive |-> !p60_oe) else $error("p60 not driven");
   a_t1_pulse: assert property (
      timer_one_tick |-> pulse_once(timer_one_tick)) else $error("timer one tick too long");
   a_t2_pulse: assert property (
      timer_two_tick |-> pulse_once(timer_two_tick)) else $error("timer two tick too long");
   a_t1_idle: assert property (
      !timer_one_run && !$past(timer_one_run) |-> !timer_one_tick) else $error("stopped tick");
endmodule

`default_nettype wire

// ### sim/pin_partner.sv
// far side of the bank: comparator, pwm source and the port5 bit0 pin
// assumes the bench sets comparator and pin levels by nonblocking writes at the clock edge
`default_nettype none

module pin_partner (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic cmp_level,
   input  wire logic pin_level,
   output logic      cmp_raw,
   output logic      pwm1_wave,
   output logic      cmp_pin_src,
   output logic      port5_bit0_in
);
   timeunit 1ns;
   timeprecision 1ps;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         pwm1_wave <= 1'b0;
      else
         pwm1_wave <= ~pwm1_wave;
   end

   assign cmp_raw       = cmp_level;
   // op output follows the comparator; no adc load on the shared pin is modelled
   assign cmp_pin_src   = cmp_level;
   assign port5_bit0_in = pin_level;
endmodule

`default_nettype wire

// ### sim/test_peripheral_control_bank.sv
// self-checking bench for the peripheral control bank
// assumes the consts header on the include path and the pin partner model
`default_nettype none
`include "periph_bank_consts.svh"

module test_peripheral_control_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, wr, rd, cmp_level, pin_level, port5_direction_b1;
   logic [`ADDR_W-1:0] addr;
   logic [7:0] wdata;
   logic port5_direction_b0 = 1'b1, port6_direction_b0 = 1'b1;
   logic port5_bit0_data = 1'b0, port5_bit1_data = 1'b1, port6_bit0_data = 1'b1;
   wire logic [7:0] rdata, p6_pull_down_en, p5_open_drain_en, pull_up_en;
   wire logic cmp_raw, pwm1_wave, cmp_pin_src, port5_bit0_in, pwm_ch_one_enable, timer_one_run,
      timer_two_run, timer_three_run, timer_one_tick, timer_two_tick, timer_three_tick,
      watchdog_on, watchdog_tick, cmp_enable, opamp_enable, cmp_pin_drive, ext_irq_enable,
      ext_irq_n, port5_bit0_read, p50_out, p50_oe, p51_out, p51_oe, p60_out, p60_oe;
   int fail_count = 0, compares = 0, cyc = 0, n;
   logic [7:0] m [8] = '{`PWM_T1_MASK, `T23_MASK, `CMP_WR_MASK, 8'hFF, 8'hFF, 8'hFF,
                         `WD_MASK, 8'h00};
   logic [2:0] fx [4] = '{3'h0, 3'h4, 3'h5, 3'h7};

   peripheral_control_bank dut (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .cmp_raw,
      .pwm1_wave, .cmp_pin_src, .port5_direction_b0, .port5_direction_b1, .port6_direction_b0,
      .port5_bit0_data, .port5_bit1_data, .port6_bit0_data, .port5_bit0_in, .pwm_ch_one_enable,
      .timer_one_run, .timer_two_run, .timer_three_run, .timer_one_tick, .timer_two_tick,
      .timer_three_tick, .watchdog_on, .watchdog_tick, .cmp_enable, .opamp_enable,
      .cmp_pin_drive, .ext_irq_enable, .ext_irq_n, .port5_bit0_read, .p50_out, .p50_oe,
      .p51_out, .p51_oe, .p60_out, .p60_oe, .p6_pull_down_en, .p5_open_drain_en, .pull_up_en);
   pin_partner far (.clk, .rst_b, .cmp_level, .pin_level, .cmp_raw, .pwm1_wave, .cmp_pin_src,
      .port5_bit0_in);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task end_sim;
      if (fail_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // whole run needs about 7000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         end_sim();
      end
   end

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   task wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(nm, e, rdata);
   endtask

   // derived outputs land one edge after the write; pin enables one more
   task settle;
      repeat (3) @(negedge clk);
   endtask

   function logic tk(input int s);
      case (s)
         0: return timer_one_tick;
         1: return timer_two_tick;
         2: return timer_three_tick;
         default: return watchdog_tick;
      endcase
   endfunction

   // skips the first tick after a change, then measures one full period
   task gap(input int s, input int e, input string nm);
      n = 0;
      repeat (2) begin
         @(negedge clk);
         while (tk(s) !== 1'b1 && n < 900) begin
            @(negedge clk);
            n++;
         end
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tk(s) !== 1'b1 && n < 900);
      chk(nm, e, n);
   endtask

   initial begin
      rst_b = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = 8'h00;
      cmp_level = 1'b0;
      pin_level = 1'b1;
      port5_direction_b1 = 1'b1;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 8; a++)
         rd_chk(3'(a), (a > 2 && a < 6) ? 8'hFF : 8'h00, "reset_value");
      for (int a = 0; a < 8; a++) begin
         wr_reg(3'(a), 8'hFF);
         rd_chk(3'(a), m[a], "ones_readback");
         wr_reg(3'(a), 8'h00);
         rd_chk(3'(a), 8'h00, "zeros_readback");
      end
      @(posedge clk);
      cmp_level <= 1'b1;
      settle();
      rd_chk(3'h2, 8'h04, "cmp_result");
      for (int f = 0; f < 4; f++) begin
         wr_reg(3'h2, 8'(f));
         settle();
         chk("fn_decode", fx[f], {cmp_enable, opamp_enable, cmp_pin_drive});
      end
      chk("p60_takeover", 2'h1, {p60_oe, p60_out});
      wr_reg(3'h2, 8'h00);
      settle();
      chk("p60_port", 2'h3, {p60_oe, p60_out});
      wr_reg(3'h3, 8'hA5);
      wr_reg(3'h4, 8'h3C);
      wr_reg(3'h5, 8'h96);
      settle();
      chk("pull_down", 8'h5A, p6_pull_down_en);
      chk("open_drain", 8'hC3, p5_open_drain_en);
      chk("pull_high", 8'h69, pull_up_en);
      wr_reg(3'h0, 8'h20);
      settle();
      chk("pwm_takeover", 1'b0, p51_oe);
      wr_reg(3'h0, 8'h00);
      settle();
      chk("p51_port", 2'h3, {p51_oe, p51_out});
      for (int c = 0; c < 8; c++) begin
         wr_reg(3'h0, 8'h08 | 8'(c));
         gap(0, 2 << c, "t1_ratio");
         wr_reg(3'h1, {2'h3, 3'(c), 3'(7 - c)});
         gap(1, 2 << (7 - c), "t2_ratio");
         gap(2, 2 << c, "t3_ratio");
         wr_reg(3'h6, 8'hA0 | 8'(c << 2));
         gap(3, 2 << c, "wd_ratio");
      end
      wr_reg(3'h6, 8'h80);
      gap(3, 1, "wd_direct");
      chk("runs_on", 4'hF, {timer_one_run, timer_two_run, timer_three_run, watchdog_on});
      wr_reg(3'h0, 8'h07);
      wr_reg(3'h1, 8'h00);
      settle();
      chk("runs_off", 3'h0, {timer_one_run, timer_two_run, timer_three_run});
      n = 0;
      for (int i = 0; i < 600; i++) begin
         @(negedge clk);
         n += int'((timer_one_tick | timer_two_tick | timer_three_tick) !== 1'b0);
      end
      chk("stopped_ticks", 0, n);
      @(posedge clk);
      pin_level <= 1'b0;
      wr_reg(3'h6, 8'h40);
      settle();
      chk("irq_pin_low", 2'h0, {ext_irq_n, port5_bit0_read});
      @(posedge clk);
      pin_level <= 1'b1;
      settle();
      chk("irq_pin_high", 2'h3, {ext_irq_n, port5_bit0_read});
      wr_reg(3'h6, 8'h00);
      pin_level <= 1'b0;
      settle();
      chk("irq_masked", 2'h2, {ext_irq_n, port5_bit0_read});
      chk("p50_port", 2'h2, {p50_oe, p50_out});
      end_sim();
   end
endmodule

bind peripheral_control_bank peripheral_control_bank_props props (.clk, .rst_b,
   .pwm_ch_one_enable, .p51_oe, .ext_irq_enable, .ext_irq_n, .port5_bit0_in, .port5_bit0_read,
   .cmp_enable, .opamp_enable, .cmp_pin_drive, .p60_oe, .timer_one_run, .timer_one_tick,
   .timer_two_tick);

`default_nettype wire

// ### src/periph_bank_consts.svh
// register offsets, field positions and reset values of the peripheral control bank
// assumes inclusion by bare name from the package and the bank module
`ifndef PERIPH_BANK_CONSTS_SVH
`define PERIPH_BANK_CONSTS_SVH

`define ADDR_W              3
`define OFF_PWM_T1          3'h0
`define OFF_T23             3'h1
`define OFF_CMP             3'h2
`define OFF_PULL_DOWN       3'h3
`define OFF_OPEN_DRAIN      3'h4
`define OFF_PULL_HIGH       3'h5
`define OFF_WATCHDOG        3'h6

`define PWM1_EN_BIT         5
`define T1_RUN_BIT          3
`define T1_PS_LSB           0
`define T3_RUN_BIT          7
`define T2_RUN_BIT          6
`define T3_PS_LSB           3
`define T2_PS_LSB           0
`define CMP_RESULT_BIT      2
`define AFS_LSB             0
`define WD_ON_BIT           7
`define EIS_BIT             6
`define WD_PS_ON_BIT        5
`define WD_PS_LSB           2

`define PWM_T1_MASK         8'h2F
`define T23_MASK            8'hFF
`define CMP_WR_MASK         8'h03
`define WD_MASK             8'hFC

`define RST_CTRL            8'h00
`define RST_PORT_CFG        8'hFF
`define ZERO_BYTE           8'h00

`endif

// ### src/periph_bank_pkg.sv
// types shared by the peripheral control bank
// assumes the consts header is on the include path
`default_nettype none
`include "periph_bank_consts.svh"

package periph_bank_pkg;

   typedef enum logic [1:0] {
      afs_off      = 2'b00,
      afs_cmp_io   = 2'b01,
      afs_cmp_pin  = 2'b10,
      afs_opamp    = 2'b11
   } analog_fn_e;

   typedef struct packed {
      logic [7:0] pwm_timer_one_control;
      logic [7:0] timer_two_three_control;
      logic [1:0] analog_function_sel;
      logic       cmp_result;
      logic [7:0] pull_down_control;
      logic [7:0] open_drain_control;
      logic [7:0] pull_high_control;
      logic [7:0] watchdog_control;
      logic [7:0] rdata;
      logic [8:0] t1_div;
      logic [8:0] t2_div;
      logic [8:0] t3_div;
      logic [8:0] wd_div;
      logic       pwm_ch_one_enable;
      logic       timer_one_run;
      logic       timer_two_run;
      logic       timer_three_run;
      logic       watchdog_on;
      logic       cmp_enable;
      logic       opamp_enable;
      logic       cmp_pin_drive;
      logic       ext_irq_enable;
      logic       p51_oe;
      logic       p51_out;
      logic       p60_oe;
      logic       p60_out;
      logic       p50_oe;
      logic       p50_out;
      logic       port5_bit0_read;
      logic       ext_irq_n;
      logic [7:0] p6_pull_down_en;
      logic [7:0] p5_open_drain_en;
      logic [7:0] pull_up_en;
   } bank_state_s;

endpackage

`default_nettype wire

// ### src/peripheral_control_bank.sv
// peripheral control bank: seven byte-wide control/status registers and pin takeover
// assumes a synchronous cpu-side port and pin-side signals already in the clk domain
//
// Overview of operation
// - pwm one enable 0 keeps port pin; 1 drives pwm, forces output direction.
// - bit 4 of pwm/timer-one register always reads zero.
// - timer-one run bit 3 stops timer at 0, runs it at 1.
// - timer-one prescale bits 2..0 divide by 2^(code+1).
// - timer control bit 7 turns timer three on, default off.
// - timer control bit 6 turns timer two on, default off.
// - timer-three prescale bits 5..3 divide 1:2 up to 1:256.
// - timer-two prescale bits 2..0 divide 1:2 up to 1:256.
// - comparator register bits 7..3 always read zero.
// - comparator register bit 2 shows live comparator result.
// - function select: off, comparator, comparator on pin, op-amp on pin.
// - pull-down bit n at 0 enables port6 pin n pull-down.
// - open-drain bit n at 0 makes port5 pin n open-drain.
// - pull-high bits 7..4 port6, 3..0 port5; 0 enables pull-up.
// - pull-down, open-drain, pull-high registers fully read/write.
// - watchdog bit 7 enables watchdog, read/write.
// - watchdog bit 6 makes port5 pin0 the active-low interrupt input.
// - interrupt path masked when select is 0; pin still readable when 1.
// - watchdog bit 5 at 0 gives rate 1:1, else prescale field.
// - watchdog prescale 1:2 to 1:256; bits 1..0 read zero.
// - direction bit 1 makes pin input, 0 makes it output.
//
// Chosen here: the register addresses and the plain strobed port.
`default_nettype none
`include "periph_bank_consts.svh"

module peripheral_control_bank #(
   parameter int DIV_W = 9
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic [`ADDR_W-1:0]   addr,
   input  wire logic [7:0]           wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic [7:0]                rdata,
   input  wire logic                 cmp_raw,
   input  wire logic                 pwm1_wave,
   input  wire logic                 cmp_pin_src,
   input  wire logic                 port5_direction_b0,
   input  wire logic                 port5_direction_b1,
   input  wire logic                 port6_direction_b0,
   input  wire logic                 port5_bit0_data,
   input  wire logic                 port5_bit1_data,
   input  wire logic                 port6_bit0_data,
   input  wire logic                 port5_bit0_in,
   output logic                      pwm_ch_one_enable,
   output logic                      timer_one_run,
   output logic                      timer_two_run,
   output logic                      timer_three_run,
   output logic                      timer_one_tick,
   output logic                      timer_two_tick,
   output logic                      timer_three_tick,
   output logic                      watchdog_on,
   output logic                      watchdog_tick,
   output logic                      cmp_enable,
   output logic                      opamp_enable,
   output logic                      cmp_pin_drive,
   output logic                      ext_irq_enable,
   output logic                      ext_irq_n,
   output logic                      port5_bit0_read,
   output logic                      p50_out,
   output logic                      p50_oe,
   output logic                      p51_out,
   output logic                      p51_oe,
   output logic                      p60_out,
   output logic                      p60_oe,
   output logic [7:0]                p6_pull_down_en,
   output logic [7:0]                p5_open_drain_en,
   output logic [7:0]                pull_up_en
);

   periph_bank_pkg::bank_state_s st;
   periph_bank_pkg::bank_state_s next_st;

   // ratio 2^(code+1): terminal count for a free-running divider
   function automatic logic [8:0] div_limit(input logic [2:0] code);
      div_limit = 9'((9'h002 << code) - 9'h001);
   endfunction

   // one tick per ratio period while enabled; counter parks at zero when stopped
   function automatic logic [8:0] div_step(input logic [8:0] cnt, input logic run,
                                           input logic [8:0] lim);
      if (!run)
         div_step = 9'h000;
      else if (cnt >= lim)
         div_step = 9'h000;
      else
         div_step = 9'(cnt + 9'h001);
   endfunction

   logic [2:0] t1_code;
   logic [2:0] t2_code;
   logic [2:0] t3_code;
   logic [2:0] wd_code;
   assign t1_code = st.pwm_timer_one_control[`T1_PS_LSB +: 3];
   assign t2_code = st.timer_two_three_control[`T2_PS_LSB +: 3];
   assign t3_code = st.timer_two_three_control[`T3_PS_LSB +: 3];
   assign wd_code = st.watchdog_control[`WD_PS_LSB +: 3];

   logic       wd_ps_on;
   logic       ext_irq_pin_select;
   logic [8:0] wd_lim;
   assign wd_ps_on = st.watchdog_control[`WD_PS_ON_BIT];
   assign ext_irq_pin_select      = st.watchdog_control[`EIS_BIT];
   assign wd_lim   = wd_ps_on ? div_limit(wd_code) : 9'h000;

   periph_bank_pkg::analog_fn_e afs;
   assign afs = periph_bank_pkg::analog_fn_e'(st.analog_function_sel);

   always_comb begin
      next_st = st;
      if (wr) begin
         unique case (addr)
            `OFF_PWM_T1:     next_st.pwm_timer_one_control = wdata & `PWM_T1_MASK;
            `OFF_T23:        next_st.timer_two_three_control = wdata & `T23_MASK;
            `OFF_CMP:        next_st.analog_function_sel = wdata[`AFS_LSB +: 2];
            `OFF_PULL_DOWN:  next_st.pull_down_control = wdata;
            `OFF_OPEN_DRAIN: next_st.open_drain_control = wdata;
            `OFF_PULL_HIGH:  next_st.pull_high_control = wdata;
            `OFF_WATCHDOG:   next_st.watchdog_control = wdata & `WD_MASK;
            default: ;
         endcase
      end
      next_st.cmp_result = cmp_raw;
      next_st.rdata = `ZERO_BYTE;
      if (rd) begin
         unique case (addr)
            `OFF_PWM_T1:     next_st.rdata = st.pwm_timer_one_control & `PWM_T1_MASK;
            `OFF_T23:        next_st.rdata = st.timer_two_three_control;
            `OFF_CMP:        next_st.rdata = {5'b0_0000, st.cmp_result,
                                              st.analog_function_sel};
            `OFF_PULL_DOWN:  next_st.rdata = st.pull_down_control;
            `OFF_OPEN_DRAIN: next_st.rdata = st.open_drain_control;
            `OFF_PULL_HIGH:  next_st.rdata = st.pull_high_control;
            `OFF_WATCHDOG:   next_st.rdata = st.watchdog_control & `WD_MASK;
            default:         next_st.rdata = `ZERO_BYTE;
         endcase
      end

      next_st.pwm_ch_one_enable = st.pwm_timer_one_control[`PWM1_EN_BIT];
      next_st.timer_one_run     = st.pwm_timer_one_control[`T1_RUN_BIT];
      next_st.timer_three_run   = st.timer_two_three_control[`T3_RUN_BIT];
      next_st.timer_two_run     = st.timer_two_three_control[`T2_RUN_BIT];
      next_st.watchdog_on       = st.watchdog_control[`WD_ON_BIT];

      next_st.t1_div = div_step(st.t1_div, st.timer_one_run, div_limit(t1_code));
      next_st.t3_div = div_step(st.t3_div, st.timer_three_run, div_limit(t3_code));
      next_st.t2_div = div_step(st.t2_div, st.timer_two_run, div_limit(t2_code));
      next_st.wd_div = div_step(st.wd_div, st.watchdog_on, wd_lim);

      next_st.cmp_enable    = (afs != periph_bank_pkg::afs_off);
      next_st.opamp_enable  = (afs == periph_bank_pkg::afs_opamp);
      next_st.cmp_pin_drive = (afs == periph_bank_pkg::afs_cmp_pin) ||
                              (afs == periph_bank_pkg::afs_opamp);

      // output enables are active low: 0 means the pin is driven
      if (st.pwm_ch_one_enable) begin
         next_st.p51_oe  = 1'b0;
         next_st.p51_out = pwm1_wave;
      end else begin
         next_st.p51_oe  = port5_direction_b1;
         next_st.p51_out = port5_bit1_data;
      end
      if (st.cmp_pin_drive) begin
         next_st.p60_oe  = 1'b0;
         next_st.p60_out = cmp_pin_src;
      end else begin
         next_st.p60_oe  = port6_direction_b0;
         next_st.p60_out = port6_bit0_data;
      end
      // interrupt use relies on software setting the direction bit to input
      next_st.p50_oe  = port5_direction_b0;
      next_st.p50_out = port5_bit0_data;

      next_st.ext_irq_enable  = ext_irq_pin_select;
      next_st.ext_irq_n       = ext_irq_pin_select ? port5_bit0_in : 1'b1;
      next_st.port5_bit0_read = port5_bit0_in;

      next_st.p6_pull_down_en  = ~st.pull_down_control;
      next_st.p5_open_drain_en = ~st.open_drain_control;
      next_st.pull_up_en       = ~st.pull_high_control;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.pull_down_control  <= `RST_PORT_CFG;
         st.open_drain_control <= `RST_PORT_CFG;
         st.pull_high_control  <= `RST_PORT_CFG;
         st.p51_oe             <= 1'b1;
         st.p60_oe             <= 1'b1;
         st.p50_oe             <= 1'b1;
         st.ext_irq_n          <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ticks are registered wrap points of each divider
   logic t1_tick_q;
   logic t2_tick_q;
   logic t3_tick_q;
   logic wd_tick_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         t1_tick_q <= 1'b0;
         t2_tick_q <= 1'b0;
         t3_tick_q <= 1'b0;
         wd_tick_q <= 1'b0;
      end else begin
         t1_tick_q <= st.timer_one_run && (st.t1_div >= div_limit(t1_code));
         t2_tick_q <= st.timer_two_run && (st.t2_div >= div_limit(t2_code));
         t3_tick_q <= st.timer_three_run && (st.t3_div >= div_limit(t3_code));
         wd_tick_q <= st.watchdog_on && (st.wd_div >= wd_lim);
      end
   end

   assign rdata             = st.rdata;
   assign pwm_ch_one_enable = st.pwm_ch_one_enable;
   assign timer_one_run     = st.timer_one_run;
   assign timer_two_run     = st.timer_two_run;
   assign timer_three_run   = st.timer_three_run;
   assign timer_one_tick    = t1_tick_q;
   assign timer_two_tick    = t2_tick_q;
   assign timer_three_tick  = t3_tick_q;
   assign watchdog_on       = st.watchdog_on;
   assign watchdog_tick     = wd_tick_q;
   assign cmp_enable        = st.cmp_enable;
   assign opamp_enable      = st.opamp_enable;
   assign cmp_pin_drive     = st.cmp_pin_drive;
   assign ext_irq_enable    = st.ext_irq_enable;
   assign ext_irq_n         = st.ext_irq_n;
   assign port5_bit0_read   = st.port5_bit0_read;
   assign p50_out           = st.p50_out;
   assign p50_oe            = st.p50_oe;
   assign p51_out           = st.p51_out;
   assign p51_oe            = st.p51_oe;
   assign p60_out           = st.p60_out;
   assign p60_oe            = st.p60_oe;
   assign p6_pull_down_en   = st.p6_pull_down_en;
   assign p5_open_drain_en  = st.p5_open_drain_en;
   assign pull_up_en        = st.pull_up_en;

endmodule

`default_nettype wire
